// ===== core/melody_buzzer_driver.sv
// melody sequencer and buzzer driver with its two registers
// assumes program memory answers one cycle after rom_rd, same clock
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module melody_buzzer_driver #(
	parameter logic IDLE_NEG_LEVEL = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [melody_pkg::REG_AW-1:0] reg_addr,
	input wire logic [3:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [3:0] reg_rdata,
	// start instruction
	input wire logic tune_start_instr,
	input wire logic [melody_pkg::ROM_AW-1:0] tune_start_addr,
	// program memory
	output logic rom_rd,
	output logic [melody_pkg::ROM_AW-1:0] rom_addr,
	input wire logic [15:0] rom_data,
	// interrupt request
	output logic tune_done_irq,
	// pins
	output logic tune_out_pos,
	output logic tune_out_neg
);

	typedef struct packed {
		logic [3:0] beat_rate;
		logic tune_active_flag;
		logic beeper_enable;
		logic beeper_mode_sel_hi;
		logic beeper_mode_sel_lo;
		logic [3:0] rdata;
		melody_pkg::play_state_type state;
		logic [melody_pkg::ROM_AW-1:0] next_addr;
		logic [melody_pkg::ROM_AW-1:0] pend_addr;
		logic pend;
		logic last;
		logic [6:0] tone;
		logic [10:0] units;
		logic [melody_pkg::TB_W-1:0] tb;
		logic tap32_prev;
		logic beep_prev;
		logic [1:0] falls;
		logic rom_rd;
		logic [melody_pkg::ROM_AW-1:0] rom_addr;
		logic irq;
		logic out_pos;
		logic out_neg;
	} drv_state_type;

	drv_state_type st_reg;
	drv_state_type st_next;

	logic tb_tick;
	logic tone_tick;
	logic tone_wave;
	logic audible;
	logic [7:0] tone_half;

	function automatic logic [10:0] note_units(input logic [3:0] tp, input logic [5:0] len);
		logic [4:0] tp_eff;
		logic [6:0] len_eff;
		tp_eff = (tp == 4'h0) ? 5'h02 : {1'b0, tp} + 5'h01;
		len_eff = (len == 6'h00) ? 7'h02 : {1'b0, len} + 7'h01;
		note_units = 11'(tp_eff * len_eff);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// time base and tone clocks

	tick_divider #(
		.DIV(melody_pkg::TB_DIV)
	) tb_div (
		.mclk(mclk),
		.rst(rst),
		.tick(tb_tick)
	);

	tick_divider #(
		.DIV(melody_pkg::TONE_DIV)
	) tone_div (
		.mclk(mclk),
		.rst(rst),
		.tick(tone_tick)
	);

	// tone pitch from half period of N+2 ticks at twice 65536 Hz
	assign audible = st_reg.tune_active_flag && (st_reg.state == melody_pkg::ST_PLAY)
		&& (st_reg.tone[6:2] != 5'h00);
	assign tone_half = {1'b0, st_reg.tone} + 8'(melody_pkg::TONE_OFFSET);

	tone_gen tone_unit (
		.mclk(mclk),
		.rst(rst),
		.tick(tone_tick),
		.enable(audible),
		.half(tone_half),
		.wave(tone_wave)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic unit_pulse;
		logic tap32_fall;
		logic buzz_gate;
		logic buzz_level;
		logic pos;
		melody_pkg::beep_mode_type mode;
		unit_pulse = 1'b0;
		tap32_fall = 1'b0;
		buzz_gate = 1'b0;
		buzz_level = 1'b0;
		pos = 1'b0;
		mode = melody_pkg::BEEP_INTER1;
		st_next = st_reg;
		st_next.irq = 1'b0;
		st_next.rom_rd = 1'b0;

		// free-running time base
		if (tb_tick) begin
			st_next.tb = st_reg.tb + 1'b1;
		end
		unit_pulse = tb_tick && (st_reg.tb[3:0] == melody_pkg::UNIT_LAST_PHASE);
		st_next.tap32_prev = st_reg.tb[melody_pkg::TAP_32HZ];
		tap32_fall = st_reg.tap32_prev && !st_reg.tb[melody_pkg::TAP_32HZ];

		// sequencer
		unique case (st_reg.state)
			melody_pkg::ST_IDLE: begin
			end
			melody_pkg::ST_FETCH: begin
				st_next.state = melody_pkg::ST_LOAD;
			end
			melody_pkg::ST_LOAD: begin
				st_next.last = rom_data[melody_pkg::WORD_LAST_BIT];
				st_next.tone = rom_data[melody_pkg::TONE_HI:melody_pkg::TONE_LO];
				st_next.units = note_units(st_reg.beat_rate,
					rom_data[melody_pkg::LEN_HI:melody_pkg::LEN_LO]);
				st_next.irq = rom_data[melody_pkg::WORD_LAST_BIT];
				st_next.next_addr = st_reg.rom_addr + 1'b1;
				st_next.state = melody_pkg::ST_PLAY;
			end
			melody_pkg::ST_PLAY: begin
				if (unit_pulse) begin
					st_next.units = st_reg.units - 1'b1;
					if (st_reg.units == 11'h001) begin
						if (st_reg.pend) begin
							st_next.pend = 1'b0;
							st_next.rom_addr = st_reg.pend_addr;
							st_next.rom_rd = 1'b1;
							st_next.state = melody_pkg::ST_FETCH;
						end else if (st_reg.last) begin
							st_next.tune_active_flag = 1'b0;
							st_next.state = melody_pkg::ST_IDLE;
						end else begin
							st_next.rom_addr = st_reg.next_addr;
							st_next.rom_rd = 1'b1;
							st_next.state = melody_pkg::ST_FETCH;
						end
					end
				end
			end
		endcase

		// single tone timeout, counted from the enable rising edge
		st_next.beep_prev = st_reg.beeper_enable;
		if (st_reg.beeper_enable && !st_reg.beep_prev) begin
			st_next.falls = 2'b00;
		end else if (st_reg.beeper_enable && tap32_fall
			&& ({st_reg.beeper_mode_sel_hi, st_reg.beeper_mode_sel_lo}
			== melody_pkg::BEEP_SINGLE)) begin
			if (st_reg.falls == 2'(melody_pkg::SINGLE_FALLS - 1)) begin
				st_next.beeper_enable = 1'b0;
			end else begin
				st_next.falls = st_reg.falls + 2'b01;
			end
		end

		// register writes
		if (reg_wr && reg_addr == melody_pkg::BEAT_RATE_OFFSET) begin
			st_next.beat_rate = reg_wdata;
		end
		if (reg_wr && reg_addr == melody_pkg::TUNE_CONTROL_OFFSET) begin
			st_next.beeper_enable = reg_wdata[melody_pkg::BEEP_EN_BIT];
			st_next.beeper_mode_sel_hi = reg_wdata[melody_pkg::MODE_HI_BIT];
			st_next.beeper_mode_sel_lo = reg_wdata[melody_pkg::MODE_LO_BIT];
			if (!reg_wdata[melody_pkg::ACTIVE_BIT]) begin
				// immediate halt; end data loaded by software is not needed here
				st_next.tune_active_flag = 1'b0;
				st_next.state = melody_pkg::ST_IDLE;
				st_next.pend = 1'b0;
				st_next.rom_rd = 1'b0;
			end
		end

		// start instruction wins over a same-cycle halt
		if (tune_start_instr) begin
			if (st_next.tune_active_flag) begin
				st_next.pend = 1'b1;
				st_next.pend_addr = tune_start_addr;
			end else begin
				st_next.tune_active_flag = 1'b1;
				st_next.rom_addr = tune_start_addr;
				st_next.rom_rd = 1'b1;
				st_next.state = melody_pkg::ST_FETCH;
			end
			st_next.beeper_enable = 1'b0;
		end

		// buzzer gating
		mode = melody_pkg::beep_mode_type'({st_reg.beeper_mode_sel_hi,
			st_reg.beeper_mode_sel_lo});
		unique case (mode)
			melody_pkg::BEEP_INTER1: begin
				buzz_gate = st_reg.tb[melody_pkg::TAP_8HZ];
			end
			melody_pkg::BEEP_INTER2: begin
				buzz_gate = st_reg.tb[melody_pkg::TAP_8HZ]
					&& !st_reg.tb[melody_pkg::TAP_1HZ];
			end
			melody_pkg::BEEP_SINGLE: begin
				buzz_gate = 1'b1;
			end
			melody_pkg::BEEP_CONT: begin
				buzz_gate = 1'b1;
			end
		endcase
		buzz_level = st_reg.beeper_enable && buzz_gate
			&& st_reg.tb[melody_pkg::TAP_4K];

		// pin drive, melody first
		if (st_reg.tune_active_flag) begin
			pos = audible && tone_wave;
		end else begin
			pos = buzz_level;
		end
		st_next.out_pos = pos;
		if (st_reg.tune_active_flag || st_reg.beeper_enable) begin
			st_next.out_neg = ~pos;
		end else begin
			st_next.out_neg = IDLE_NEG_LEVEL;
		end

		// read data one cycle after the strobe
		st_next.rdata = 4'h0;
		if (reg_rd && reg_addr == melody_pkg::BEAT_RATE_OFFSET) begin
			st_next.rdata = st_reg.beat_rate;
		end else if (reg_rd && reg_addr == melody_pkg::TUNE_CONTROL_OFFSET) begin
			st_next.rdata = {st_reg.tune_active_flag, st_reg.beeper_enable,
				st_reg.beeper_mode_sel_hi, st_reg.beeper_mode_sel_lo};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.beat_rate <= melody_pkg::BEAT_RATE_RESET;
			st_reg.out_neg <= IDLE_NEG_LEVEL;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign rom_rd = st_reg.rom_rd;
	assign rom_addr = st_reg.rom_addr;
	assign tune_done_irq = st_reg.irq;
	assign tune_out_pos = st_reg.out_pos;
	assign tune_out_neg = st_reg.out_neg;

endmodule

// ===== core/melody_pkg.sv
// melody and buzzer driver: shared constants and types
// assumes a single 20 MHz clock and a nibble-wide register port
package melody_pkg;

	// clock and time base
	localparam int CLK_HZ = 20000000;
	localparam int TB_TICK_HZ = 8192;
	localparam int TONE_TICK_HZ = 131072;
	localparam int TB_DIV = CLK_HZ / TB_TICK_HZ;
	localparam int TONE_DIV = CLK_HZ / TONE_TICK_HZ;
	localparam int TB_W = 13;
	localparam int TAP_4K = 0;
	localparam int TAP_32HZ = 7;
	localparam int TAP_8HZ = 9;
	localparam int TAP_1HZ = 12;

	// note length unit
	localparam longint UNIT_NS = 64'd1953125;
	localparam int UNIT_TB_TICKS = int'((UNIT_NS * TB_TICK_HZ) / 64'd1000000000);
	localparam logic [3:0] UNIT_LAST_PHASE = 4'(UNIT_TB_TICKS - 1);

	// register map
	localparam int REG_AW = 10;
	localparam logic [REG_AW-1:0] BEAT_RATE_OFFSET = 10'h096;
	localparam logic [REG_AW-1:0] TUNE_CONTROL_OFFSET = 10'h097;
	localparam logic [3:0] BEAT_RATE_RESET = 4'h0;
	localparam logic [3:0] TUNE_CONTROL_RESET = 4'h0;
	localparam int ACTIVE_BIT = 3;
	localparam int BEEP_EN_BIT = 2;
	localparam int MODE_HI_BIT = 1;
	localparam int MODE_LO_BIT = 0;

	// melody word layout
	localparam int ROM_AW = 13;
	localparam int WORD_LAST_BIT = 15;
	localparam int LEN_HI = 13;
	localparam int LEN_LO = 8;
	localparam int TONE_HI = 6;
	localparam int TONE_LO = 0;
	localparam int TONE_OFFSET = 2;
	localparam int SINGLE_FALLS = 2;

	typedef enum logic [1:0] {
		BEEP_INTER1 = 2'b00,
		BEEP_INTER2 = 2'b01,
		BEEP_SINGLE = 2'b10,
		BEEP_CONT = 2'b11
	} beep_mode_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_LOAD = 2'b10,
		ST_PLAY = 2'b11
	} play_state_type;

endpackage

// ===== core/tick_divider.sv
// enable pulse divider: one-cycle pulse every DIV clocks
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/10ps
module tick_divider #(
	parameter int DIV = 2441
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// enable pulse
	output logic tick
);
	localparam int CW = $clog2(DIV);

	typedef struct packed {
		logic [CW-1:0] count;
		logic tick;
	} div_state_type;

	div_state_type st_reg;
	div_state_type st_next;

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.count == CW'(DIV - 1)) begin
			st_next.count = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.count = st_reg.count + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;
endmodule

// ===== core/tone_gen.sv
// square wave of period 2*half ticks, held low while disabled
// assumes tick is a one-cycle enable on the same clock
`timescale 1ns/10ps
module tone_gen (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic tick,
	input wire logic enable,
	input wire logic [7:0] half,
	// wave
	output logic wave
);
	typedef struct packed {
		logic [7:0] count;
		logic wave;
	} tone_state_type;

	tone_state_type st_reg;
	tone_state_type st_next;

	always_comb begin
		st_next = st_reg;
		if (!enable) begin
			st_next = '0;
		end else if (tick) begin
			if (st_reg.count >= half - 8'h01) begin
				st_next.count = 8'h00;
				st_next.wave = ~st_reg.wave;
			end else begin
				st_next.count = st_reg.count + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wave = st_reg.wave;
endmodule

// ===== test/melody_buzzer_driver_sva.sv
// port checker for the melody and buzzer driver
// assumes the bench keeps one request per cycle
`timescale 1ns/10ps
module melody_buzzer_driver_sva #(
	parameter logic IDLE_NEG_LEVEL = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [melody_pkg::REG_AW-1:0] reg_addr,
	input wire logic [3:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_rdata,
	// start and memory
	input wire logic tune_start_instr,
	input wire logic [melody_pkg::ROM_AW-1:0] tune_start_addr,
	input wire logic rom_rd,
	input wire logic [melody_pkg::ROM_AW-1:0] rom_addr,
	input wire logic [15:0] rom_data,
	// outputs
	input wire logic tune_done_irq,
	input wire logic tune_out_pos,
	input wire logic tune_out_neg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence start_fetch;
		tune_start_instr ##1 rom_rd;
	endsequence
	sequence last_fetch;
		rom_rd ##1 rom_data[15];
	endsequence
	sequence beat_wr_rd;
		reg_wr && reg_addr == melody_pkg::BEAT_RATE_OFFSET ##1
			reg_rd && reg_addr == melody_pkg::BEAT_RATE_OFFSET;
	endsequence
	sequence start_rd;
		tune_start_instr ##1 reg_rd && reg_addr == melody_pkg::TUNE_CONTROL_OFFSET;
	endsequence
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 4'h0)
		else $error("read data outside answer cycle");
	AST_BEAT_RW: assert property (beat_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
		else $error("beat rate read back differs");
	AST_START_FLAGS: assert property (start_rd |=> reg_rdata[3] && !reg_rdata[2])
		else $error("start did not set active or clear beeper");
	AST_ROM_ADDR: assert property (start_fetch |-> rom_addr == $past(tune_start_addr))
		else $error("first fetch not at start address");
	AST_ROM_PULSE: assert property (rom_rd |=> !rom_rd)
		else $error("fetch request longer than one cycle");
	AST_IRQ_SET: assert property (last_fetch |=> tune_done_irq)
		else $error("no done request for last word");
	AST_IRQ_CAUSE: assert property (tune_done_irq |-> $past(rom_rd, 2) && $past(rom_data[15]))
		else $error("done request without last word");
	AST_NEG_COMPL: assert property (tune_out_pos |-> !tune_out_neg)
		else $error("pin pair not complementary");
	AST_STOP_IDLE: assert property ((reg_wr && reg_addr == melody_pkg::TUNE_CONTROL_OFFSET
		&& reg_wdata == 4'h0 && !tune_start_instr) |-> ##2
		(!tune_out_pos && tune_out_neg == IDLE_NEG_LEVEL))
		else $error("pins not idle after stop");
endmodule
bind melody_buzzer_driver melody_buzzer_driver_sva #(.IDLE_NEG_LEVEL(IDLE_NEG_LEVEL)) sva_inst (
	.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tune_start_instr,
	.tune_start_addr, .rom_rd, .rom_addr, .rom_data, .tune_done_irq, .tune_out_pos,
	.tune_out_neg);

// ===== test/melody_buzzer_driver_tb_top.sv
// bench for the melody and buzzer driver
// assumes rom_model answers fetches; registers reached by strobes
`timescale 1ns/10ps
module melody_buzzer_driver_tb_top;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] reg_addr = 10'h000;
	logic [3:0] reg_wdata = 4'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] reg_rdata;
	logic tune_start_instr = 1'b0;
	logic [12:0] tune_start_addr = 13'h0000;
	logic rom_rd;
	logic [12:0] rom_addr;
	logic [15:0] rom_data;
	logic tune_done_irq;
	logic tune_out_pos;
	logic tune_out_neg;
	int error_cnt = 0;
	int cmp_count = 0;
	int irq_cnt = 0;
	int tg;
	always #25 mclk = ~mclk;
	melody_buzzer_driver melody_buzzer_driver_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tune_start_instr(tune_start_instr), .tune_start_addr(tune_start_addr), .rom_rd(rom_rd),
		.rom_addr(rom_addr), .rom_data(rom_data), .tune_done_irq(tune_done_irq),
		.tune_out_pos(tune_out_pos), .tune_out_neg(tune_out_neg));
	rom_model rom_model_inst (.mclk(mclk), .rom_rd(rom_rd), .rom_addr(rom_addr),
		.rom_data(rom_data));
	always @(posedge mclk) if (tune_done_irq === 1'b1) irq_cnt++;
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [9:0] a, input logic [3:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [9:0] a, input logic [3:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task wr_rd(input logic [9:0] a, input logic [3:0] d, input logic [3:0] exp);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task start(input logic [12:0] a, input logic [3:0] exp);
		@(posedge mclk);
		tune_start_instr <= 1'b1;
		tune_start_addr <= a;
		@(posedge mclk);
		tune_start_instr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= 10'h097;
		#1 chk({rom_rd, rom_addr}, {1'b1, a});
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task restart(input logic [12:0] a);
		@(posedge mclk);
		tune_start_instr <= 1'b1;
		tune_start_addr <= a;
		@(posedge mclk);
		tune_start_instr <= 1'b0;
		#1 chk(16'(rom_rd), 16'h0000);
	endtask
	task toggles(input int n);
		logic prev;
		tg = 0;
		prev = tune_out_pos;
		repeat (n) begin
			@(posedge mclk);
			#1;
			if (tune_out_pos !== prev) tg++;
			prev = tune_out_pos;
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(60000 * 50);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		#1 chk({tune_out_pos, tune_out_neg}, 16'h0000);
		rd(10'h096, 4'h0);
		rd(10'h097, 4'h0);
		wr_rd(10'h096, 4'hF, 4'hF);
		wr(10'h098, 4'h5);
		rd(10'h098, 4'h0);
		wr(10'h097, 4'h8);
		rd(10'h097, 4'h0);
		for (int m = 0; m < 4; m++) begin
			wr_rd(10'h097, 4'(m), 4'(m));
		end
		wr_rd(10'h097, 4'h4, 4'h4);
		toggles(5000);
		chk(16'(tg), 16'h0000);
		wr_rd(10'h097, 4'h5, 4'h5);
		toggles(5000);
		chk(16'(tg), 16'h0000);
		wr_rd(10'h097, 4'h6, 4'h6);
		toggles(5000);
		chk(16'(tg >= 2 && tg <= 3), 16'h0001);
		wr(10'h097, 4'h7);
		rd(10'h097, 4'h7);
		toggles(12000);
		chk(16'(tg >= 4 && tg <= 5), 16'h0001);
		start(13'h0200, 4'hB);
		chk(16'(irq_cnt), 16'h0001);
		rd(10'h097, 4'hB);
		toggles(3000);
		chk({15'(tg), tune_out_neg}, 16'h0001);
		wr(10'h097, 4'h0);
		rd(10'h097, 4'h0);
		chk({tune_out_pos, tune_out_neg}, 16'h0000);
		start(13'h0100, 4'h8);
		chk(16'(irq_cnt), 16'h0001);
		toggles(4000);
		chk(16'(tg >= 3 && tg <= 5), 16'h0001);
		rd(10'h097, 4'h8);
		restart(13'h0200);
		wr(10'h097, 4'h0);
		toggles(10);
		chk({tune_out_pos, tune_out_neg}, 16'h0000);
		report_and_stop();
	end
endmodule

// ===== test/rom_model.sv
// program memory model holding a few melody words
// assumes rom_rd pulses come from the driver on the same clock
`timescale 1ns/10ps
module rom_model (
	// clock
	input wire logic mclk,
	// memory port
	input wire logic rom_rd,
	input wire logic [melody_pkg::ROM_AW-1:0] rom_addr,
	output logic [15:0] rom_data
);
	logic [15:0] last_reg;
	logic valid_reg;
	initial begin
		last_reg = 16'h0000;
		valid_reg = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// word table: length, tone and end fields
	function automatic logic [15:0] word_at(logic [melody_pkg::ROM_AW-1:0] a);
		case (a)
			13'h0100: word_at = 16'h0104;
			13'h0101: word_at = 16'h8000;
			13'h0200: word_at = 16'h8000;
			default: word_at = 16'h8000;
		endcase
	endfunction
	always @(posedge mclk) begin
		valid_reg <= rom_rd;
		if (rom_rd)
			last_reg <= word_at(rom_addr);
	end
	// word stands one cycle only, inverted afterwards
	assign rom_data = valid_reg ? last_reg : ~last_reg;
endmodule
